// ==== usb_endpoint_fifo_access.sv ====
// firmware access to three endpoint buffers plus suspend and wake-up
// assumes an Avalon-MM master on the system clock and an engine on the same clock
//
// What this block does
// RULE1: firmware selects, then requests, then releases
// RULE2: direction 1 writes; toggling it ends transfer
// RULE3: flush empties selected buffer even when unready
// RULE4: select 00/01/10 picks endpoint 0/1/2
// RULE5: setup flag set by hardware, cleared by firmware
// RULE6: ready shows selected buffer accessible now
// RULE7: zero flag cleared by port read or setup
// RULE8: packets hold at most eight bytes
// RULE9: read ready falls after last byte
// RULE10: write ready falls when buffer full
// RULE11: firmware waits before sampling ready
// RULE12: firmware spaces data port accesses
// RULE13: empty packet sent by commit without data
// RULE14: endpoint 1 write sequence with ready check
// RULE15: each buffer has its own data port
// RULE16: host use blocks firmware; done raises interrupt
// RULE17: long bus idle enters suspend with interrupt
// RULE18: firmware gates usb clock in suspend
// RULE19: host resume sets resume bit, interrupt
// RULE20: firmware restores clocks after resume
// RULE21: resume bit clears before suspend bit falls; both clear in one cycle here if traffic is back when resume ends
// RULE22: remote wake write drives wake toward host
// RULE23: command register bit layout as listed
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module usb_endpoint_fifo_access
	import usb_fifo_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = usb_fifo_pkg::IDLE_SUSPEND_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [8:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire usb_fifo_pkg::sie_link_s i_link,
	output usb_fifo_pkg::sie_tx_s o_tx,
	input wire logic i_bus_active,
	input wire logic i_host_resume,
	output logic o_usb_int,
	output logic [1:0] o_active_pipe_number,
	output logic o_remote_wake
);
	import usb_fifo_pkg::*;

	localparam int unsigned CW = $clog2(IDLE_CYCLES + 1);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [6:0] index;
	logic wr_done;
	logic rd_done;
	logic cmd_write;
	logic usc_write;
	logic [7:0] wbyte;
	logic [1:0] fifo_select;
	logic request;
	logic direction;
	logic setup_flag;
	logic ready;
	logic [2:0] zero_length_flag;
	logic [2:0] flush;
	logic [2:0] port_hit;
	logic [2:0] host_hit;
	logic [2:0] mcu_read;
	logic [2:0] mcu_write;
	logic [2:0] mcu_commit;
	logic [2:0] mcu_release;
	logic [7:0] head [ENDPOINT_COUNT];
	logic [3:0] count [ENDPOINT_COUNT];
	logic [2:0] for_mcu;
	logic [2:0] for_host;
	logic [2:0] can_read;
	logic [2:0] can_write;
	logic select_valid;
	logic end_of_transfer;
	logic next_ready;
	logic [7:0] cmd_view;
	logic [7:0] usc_view;
	logic [7:0] next_read;
	logic [1:0] active_meta;
	logic [1:0] resume_meta;
	logic bus_active_s;
	logic resume_s;
	link_state_e link_state;
	logic [CW-1:0] idle_count;
	logic suspend_flag;
	logic resume_flag;
	logic link_event;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// one wait cycle on every access keeps read data registered
	assign index = i_address[8:2];
	assign wr_done = i_write && !o_waitrequest && i_byteenable[0];
	assign rd_done = i_read && !o_waitrequest;
	assign wbyte = i_writedata[7:0];
	assign cmd_write = wr_done && index == FIFO_COMMAND_STATUS_INDEX;
	assign usc_write = wr_done && index == USB_STATUS_CONTROL_INDEX;
	assign select_valid = fifo_select != 2'b11;
	// direction toggled while holding the request marks the transfer end
	assign end_of_transfer = cmd_write && request && wbyte[DIRECTION_BIT] != direction; // RULE2

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_waitrequest <= 1'b1;
		end else begin
			o_waitrequest <= !((i_read || i_write) && o_waitrequest);
		end
	end

	// ----------------------------------------------------------------
	// per endpoint buffers and strobes
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < ENDPOINT_COUNT; g++) begin : ep
			logic sel;
			assign sel = fifo_select == 2'(g); // RULE4
			assign port_hit[g] = index == ENDPOINT0_DATA_PORT_INDEX + 7'(g); // RULE15
			assign host_hit[g] = i_link.pipe == 2'(g);
			// firmware locked out while the host holds this pipe
			assign mcu_read[g] = rd_done && port_hit[g] && request && !direction
				&& sel && !(i_link.busy && host_hit[g]); // RULE16
			assign mcu_write[g] = wr_done && port_hit[g] && request && direction
				&& sel && !(i_link.busy && host_hit[g]); // RULE16
			assign mcu_commit[g] = end_of_transfer && sel && direction; // RULE14
			assign mcu_release[g] = end_of_transfer && sel && !direction && for_mcu[g];

			usb_endpoint_buffer #(
				.DEPTH(PACKET_BYTES),
				.WIDTH(8)
			) buffer (
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_flush(flush[g]),
				.i_host_write(i_link.rx_valid && host_hit[g]),
				.i_host_data(i_link.rx_data),
				.i_host_commit(i_link.rx_last && host_hit[g]),
				.i_host_take(i_link.tx_take && host_hit[g]),
				.i_host_release(i_link.done && host_hit[g] && for_host[g]),
				.i_mcu_write(mcu_write[g]),
				.i_mcu_data(wbyte),
				.i_mcu_read(mcu_read[g]),
				.i_mcu_commit(mcu_commit[g]), // RULE13
				.i_mcu_release(mcu_release[g]),
				.o_head(head[g]),
				.o_count(count[g]), // RULE8
				.o_for_mcu(for_mcu[g]),
				.o_for_host(for_host[g]),
				.o_can_read(can_read[g]),
				.o_can_write(can_write[g])
			);

			// zero flag: set by an empty packet, cleared by port read or setup
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					zero_length_flag[g] <= 1'b0;
				end else if (i_link.rx_last && i_link.rx_zero && host_hit[g]) begin
					zero_length_flag[g] <= 1'b1;
				end else if ((rd_done && port_hit[g]) || (i_link.rx_last && i_link.rx_setup)) begin
					zero_length_flag[g] <= 1'b0; // RULE7
				end
			end

			// flush is a one-cycle strobe; the bit reads back as zero
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					flush[g] <= 1'b0;
				end else begin
					flush[g] <= cmd_write && wbyte[FLUSH_BIT]
						&& {wbyte[FIFO_SELECT_HIGH_BIT], wbyte[FIFO_SELECT_LOW_BIT]} == 2'(g); // RULE3
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// command register
	// ----------------------------------------------------------------
	// firmware orders select, direction and request; no check is made here
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fifo_select <= {COMMAND_RESET[FIFO_SELECT_HIGH_BIT], COMMAND_RESET[FIFO_SELECT_LOW_BIT]};
			direction <= COMMAND_RESET[DIRECTION_BIT];
			request <= COMMAND_RESET[REQUEST_BIT];
		end else if (cmd_write) begin
			fifo_select <= {wbyte[FIFO_SELECT_HIGH_BIT], wbyte[FIFO_SELECT_LOW_BIT]}; // RULE23
			direction <= wbyte[DIRECTION_BIT]; // RULE1
			request <= wbyte[REQUEST_BIT]; // RULE1
		end
	end

	// a new setup wins over a firmware clear in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			setup_flag <= COMMAND_RESET[SETUP_BIT];
		end else if (i_link.rx_last && i_link.rx_setup) begin
			setup_flag <= 1'b1; // RULE5
		end else if (cmd_write && !wbyte[SETUP_BIT]) begin
			setup_flag <= 1'b0; // RULE5
		end
	end

	// ----------------------------------------------------------------
	// ready status
	// ----------------------------------------------------------------
	always_comb begin
		next_ready = 1'b0;
		if (request && select_valid && !(i_link.busy && i_link.pipe == fifo_select)) begin
			if (direction) begin
				next_ready = can_write[fifo_select]; // RULE10
			end else begin
				next_ready = can_read[fifo_select]; // RULE9
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ready <= 1'b0;
		end else begin
			ready <= next_ready; // RULE6
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		cmd_view = '0;
		cmd_view[ZERO_LENGTH_BIT] = select_valid && zero_length_flag[fifo_select];
		cmd_view[READY_BIT] = ready;
		cmd_view[SETUP_BIT] = setup_flag;
		cmd_view[FIFO_SELECT_HIGH_BIT] = fifo_select[1];
		cmd_view[FIFO_SELECT_LOW_BIT] = fifo_select[0];
		cmd_view[DIRECTION_BIT] = direction;
		cmd_view[REQUEST_BIT] = request;
		usc_view = STATUS_RESET;
		usc_view[SUSPEND_BIT] = suspend_flag;
		usc_view[RESUME_BIT] = resume_flag;
		next_read = '0;
		case (index)
			FIFO_COMMAND_STATUS_INDEX: next_read = cmd_view;
			USB_STATUS_CONTROL_INDEX: next_read = usc_view;
			ENDPOINT0_DATA_PORT_INDEX: next_read = head[0];
			ENDPOINT1_DATA_PORT_INDEX: next_read = head[1];
			ENDPOINT2_DATA_PORT_INDEX: next_read = head[2];
			default: next_read = '0;
		endcase
	end

	// unmapped addresses read zero and ignore writes
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_readdata <= '0;
		end else if (i_read && o_waitrequest) begin
			o_readdata <= {24'h000000, next_read};
		end
	end

	// ----------------------------------------------------------------
	// engine side
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tx <= '0;
		end else if (i_link.pipe != 2'b11) begin
			o_tx.pending <= for_host[i_link.pipe];
			o_tx.data <= head[i_link.pipe];
			o_tx.count <= count[i_link.pipe];
		end else begin
			o_tx <= '0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_active_pipe_number <= 2'b00;
		end else if (i_link.done) begin
			o_active_pipe_number <= i_link.pipe; // RULE16
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_usb_int <= 1'b0;
		end else begin
			o_usb_int <= i_link.done || link_event; // RULE16
		end
	end

	// ----------------------------------------------------------------
	// line synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			active_meta <= 2'b00;
			resume_meta <= 2'b00;
		end else begin
			active_meta <= {active_meta[0], i_bus_active};
			resume_meta <= {resume_meta[0], i_host_resume};
		end
	end
	assign bus_active_s = active_meta[1];
	assign resume_s = resume_meta[1];

	// ----------------------------------------------------------------
	// suspend and resume
	// ----------------------------------------------------------------
	// clock gating in suspend is left to firmware
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link_state <= LINK_ACTIVE;
			idle_count <= '0;
			suspend_flag <= 1'b0;
			resume_flag <= 1'b0;
			link_event <= 1'b0;
		end else begin
			link_event <= 1'b0;
			case (link_state)
				LINK_ACTIVE: begin
					if (bus_active_s) begin
						idle_count <= '0;
					end else if (idle_count == CW'(IDLE_CYCLES - 1)) begin
						idle_count <= '0;
						link_state <= LINK_SUSPENDED;
						suspend_flag <= 1'b1; // RULE17
						link_event <= 1'b1; // RULE17
					end else begin
						idle_count <= idle_count + CW'(1);
					end
				end
				LINK_SUSPENDED: begin
					if (resume_s) begin
						link_state <= LINK_RESUMING;
						resume_flag <= 1'b1; // RULE19
						link_event <= 1'b1; // RULE19
					end
				end
				LINK_RESUMING: begin
					// resume drops when resume ends, suspend in that cycle or later once traffic returns
					if (!resume_s) begin
						resume_flag <= 1'b0; // RULE21
						if (bus_active_s) begin
							link_state <= LINK_ACTIVE;
							suspend_flag <= 1'b0; // RULE21
							link_event <= 1'b1;
						end
					end
				end
				default: begin
					link_state <= LINK_ACTIVE;
				end
			endcase
		end
	end

	// wake stays driven until the host answers with resume
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_remote_wake <= 1'b0;
		end else if (resume_s || link_state == LINK_ACTIVE) begin
			o_remote_wake <= 1'b0;
		end else if (usc_write && wbyte[REMOTE_WAKE_BIT]) begin
			o_remote_wake <= 1'b1; // RULE22
		end
	end

endmodule

// ==== usb_fifo_pkg.sv ====
// constants and carriers shared by the endpoint access logic
// assumes a 40 MHz system clock and a word-addressed register map
package usb_fifo_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLOCK_HZ = 40_000_000;
	localparam int unsigned IDLE_SUSPEND_US = 3000;
	localparam int unsigned IDLE_SUSPEND_CYCLES = (CLOCK_HZ / 1_000_000) * IDLE_SUSPEND_US;

	// ----------------------------------------------------------------
	// register indexes (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [6:0] USB_STATUS_CONTROL_INDEX = 7'h1A;
	localparam logic [6:0] FIFO_COMMAND_STATUS_INDEX = 7'h46;
	localparam logic [6:0] ENDPOINT0_DATA_PORT_INDEX = 7'h48;
	localparam logic [6:0] ENDPOINT1_DATA_PORT_INDEX = 7'h49;
	localparam logic [6:0] ENDPOINT2_DATA_PORT_INDEX = 7'h4A;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned ZERO_LENGTH_BIT = 7;
	localparam int unsigned READY_BIT = 6;
	localparam int unsigned SETUP_BIT = 5;
	localparam int unsigned FIFO_SELECT_HIGH_BIT = 4;
	localparam int unsigned FIFO_SELECT_LOW_BIT = 3;
	localparam int unsigned FLUSH_BIT = 2;
	localparam int unsigned DIRECTION_BIT = 1;
	localparam int unsigned REQUEST_BIT = 0;
	localparam int unsigned SUSPEND_BIT = 0;
	localparam int unsigned REMOTE_WAKE_BIT = 1;
	localparam int unsigned RESUME_BIT = 3;
	localparam logic [7:0] COMMAND_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	localparam int unsigned ENDPOINT_COUNT = 3;
	localparam int unsigned PACKET_BYTES = 8;

	// ----------------------------------------------------------------
	// carriers toward the serial interface engine
	// ----------------------------------------------------------------
	typedef struct packed {
		logic busy;
		logic done;
		logic [1:0] pipe;
		logic rx_valid;
		logic [7:0] rx_data;
		logic rx_last;
		logic rx_setup;
		logic rx_zero;
		logic tx_take;
	} sie_link_s;

	typedef struct packed {
		logic pending;
		logic [7:0] data;
		logic [3:0] count;
	} sie_tx_s;

	typedef enum logic [1:0] {
		LINK_ACTIVE = 2'b00,
		LINK_SUSPENDED = 2'b01,
		LINK_RESUMING = 2'b11
	} link_state_e;

endpackage

// ==== usb_endpoint_buffer.sv ====
// one endpoint packet buffer shared by host engine and firmware
// assumes the owner of each side respects the held flags
`timescale 1ns/1ps
module usb_endpoint_buffer #(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned WIDTH = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_host_write,
	input wire logic [WIDTH-1:0] i_host_data,
	input wire logic i_host_commit,
	input wire logic i_host_take,
	input wire logic i_host_release,
	input wire logic i_mcu_write,
	input wire logic [WIDTH-1:0] i_mcu_data,
	input wire logic i_mcu_read,
	input wire logic i_mcu_commit,
	input wire logic i_mcu_release,
	output logic [WIDTH-1:0] o_head,
	output logic [3:0] o_count,
	output logic o_for_mcu,
	output logic o_for_host,
	output logic o_can_read,
	output logic o_can_write
);

	localparam int unsigned PW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wptr;
	logic [PW-1:0] rptr;
	logic free;

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	assign free = !o_for_mcu && !o_for_host;
	assign o_head = (rptr < PW'(DEPTH)) ? mem[rptr[PW-2:0]] : '0;
	assign o_count = 4'(wptr);
	assign o_can_read = o_for_mcu && (rptr < wptr);
	assign o_can_write = free && (wptr < PW'(DEPTH));

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (free && wptr < PW'(DEPTH)) begin
			if (i_host_write) begin
				mem[wptr[PW-2:0]] <= i_host_data;
			end else if (i_mcu_write) begin
				mem[wptr[PW-2:0]] <= i_mcu_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// pointers and ownership
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wptr <= '0;
			rptr <= '0;
			o_for_mcu <= 1'b0;
			o_for_host <= 1'b0;
		end else if (i_flush) begin
			wptr <= '0;
			rptr <= '0;
			o_for_mcu <= 1'b0;
			o_for_host <= 1'b0;
		end else if (i_mcu_release || i_host_release) begin
			wptr <= '0;
			rptr <= '0;
			o_for_mcu <= 1'b0;
			o_for_host <= 1'b0;
		end else if (i_host_commit && free) begin
			o_for_mcu <= 1'b1;
			rptr <= '0;
		end else if (i_mcu_commit && free) begin
			o_for_host <= 1'b1;
			rptr <= '0;
		end else begin
			if ((i_host_write || i_mcu_write) && o_can_write) begin
				wptr <= wptr + PW'(1);
			end
			if ((i_mcu_read && o_can_read) || (i_host_take && o_for_host && rptr < wptr)) begin
				rptr <= rptr + PW'(1);
			end
		end
	end

endmodule

// ==== usb_fifo_access_sva.sv ====
// bus, interrupt and wake-up checks for the endpoint access block
// assumes binding onto the top module ports, one clock domain
`timescale 1ns/1ps
module usb_fifo_access_sva
	import usb_fifo_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = 20
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	input wire usb_fifo_pkg::sie_link_s i_link,
	input wire logic i_bus_active,
	input wire logic i_host_resume,
	input wire logic o_usb_int,
	input wire logic [1:0] o_active_pipe_number,
	input wire logic o_remote_wake
);
	int unsigned idle_count;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// saturates, so the idle antecedent fires once per idle span
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			idle_count <= 0;
		else if (i_bus_active || i_host_resume)
			idle_count <= 0;
		else if (idle_count < IDLE_CYCLES)
			idle_count <= idle_count + 1;
	end
	a_wait_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("bus request not answered next cycle");
	a_wait_single: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_read_upper: assert property (o_readdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	a_int_pulse: assert property (o_usb_int |=> !o_usb_int)
		else $error("interrupt longer than one cycle");
	a_done_int: assert property (i_link.done |=> o_usb_int && o_active_pipe_number == $past(i_link.pipe))
		else $error("done without interrupt or pipe number");
	a_idle_suspend: assert property (idle_count == IDLE_CYCLES - 1 |-> ##[1:8] o_usb_int)
		else $error("no interrupt after bus idle");
	a_resume_int: assert property ($rose(i_host_resume) |-> ##[1:6] o_usb_int)
		else $error("no interrupt after host resume");
	a_wake_stop: assert property ($rose(i_host_resume) |-> ##[1:5] !o_remote_wake)
		else $error("wake kept after host resume");
endmodule

bind usb_endpoint_fifo_access usb_fifo_access_sva #(.IDLE_CYCLES(IDLE_CYCLES)) i_sva (
	.i_clock(i_clock),
	.i_rst_n(i_rst_n),
	.i_read(i_read),
	.i_write(i_write),
	.o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest),
	.i_link(i_link),
	.i_bus_active(i_bus_active),
	.i_host_resume(i_host_resume),
	.o_usb_int(o_usb_int),
	.o_active_pipe_number(o_active_pipe_number),
	.o_remote_wake(o_remote_wake)
);

// ==== usb_host_model.sv ====
// host and engine side model: packets in, packets out, bus line states
// assumes the access block's clock; tasks are called by the bench
`timescale 1ns/1ps
module usb_host_model
	import usb_fifo_pkg::*;
(
	input wire logic i_clock,
	input wire usb_fifo_pkg::sie_tx_s i_tx,
	output usb_fifo_pkg::sie_link_s o_link,
	output logic o_bus_active,
	output logic o_host_resume
);
	initial begin
		o_link = '0;
		o_bus_active = 1'b1;
		o_host_resume = 1'b0;
	end
	task automatic send(input logic [1:0] p, input int n, input logic [7:0] b, input logic s,
		input logic z);
		@(posedge i_clock);
		o_link.pipe <= p;
		o_link.busy <= 1'b1;
		for (int k = 0; k < n; k++) begin
			@(posedge i_clock);
			o_link.rx_valid <= 1'b1;
			o_link.rx_data <= b + 8'(k);
			@(posedge i_clock);
			o_link.rx_valid <= 1'b0;
			// no stale byte between strobes
			o_link.rx_data <= ~(b + 8'(k));
		end
		@(posedge i_clock);
		o_link.rx_last <= 1'b1;
		o_link.rx_setup <= s;
		o_link.rx_zero <= z;
		@(posedge i_clock);
		o_link.rx_last <= 1'b0;
		o_link.rx_setup <= 1'b0;
		o_link.rx_zero <= 1'b0;
		o_link.busy <= 1'b0;
	endtask
	task automatic fetch(input logic [1:0] p, output logic pend, output logic [3:0] cnt,
		output logic [63:0] bytes);
		@(posedge i_clock);
		o_link.pipe <= p;
		o_link.busy <= 1'b1;
		repeat (4) @(posedge i_clock);
		pend = i_tx.pending;
		cnt = i_tx.count;
		bytes = '0;
		for (int k = 0; k < 8 && k < cnt; k++) begin
			bytes[8*k +: 8] = i_tx.data;
			o_link.tx_take <= 1'b1;
			@(posedge i_clock);
			o_link.tx_take <= 1'b0;
			repeat (2) @(posedge i_clock);
		end
		o_link.done <= 1'b1;
		@(posedge i_clock);
		o_link.done <= 1'b0;
		o_link.busy <= 1'b0;
	endtask
	task automatic hold(input logic [1:0] p, input logic on);
		@(posedge i_clock);
		o_link.pipe <= p;
		o_link.busy <= on;
	endtask
	task automatic lines(input logic act, input logic res);
		@(posedge i_clock);
		o_bus_active <= act;
		o_host_resume <= res;
	endtask
endmodule

// ==== usb_endpoint_fifo_access_tb.sv ====
// self-checking bench for the endpoint access block
// assumes the host model drives the engine link and bus lines
`timescale 1ns/1ps
module usb_endpoint_fifo_access_tb;
	import usb_fifo_pkg::*;
	logic clk;
	logic rst_n;
	logic [8:0] addr;
	logic rd;
	logic wr_en;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic waitreq;
	sie_link_s link;
	sie_tx_s tx;
	logic act;
	logic res;
	logic irq;
	logic [1:0] pipe;
	logic wake;
	int num_errors;
	int comparisons;
	logic [7:0] d;
	logic pend;
	logic [3:0] cnt;
	logic [63:0] bytes;

	usb_endpoint_fifo_access #(.IDLE_CYCLES(20)) i_dut (.i_clock(clk), .i_rst_n(rst_n),
		.i_address(addr), .i_read(rd), .i_write(wr_en), .i_writedata(wdata),
		.i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(waitreq), .i_link(link),
		.o_tx(tx), .i_bus_active(act), .i_host_resume(res), .o_usb_int(irq),
		.o_active_pipe_number(pipe), .o_remote_wake(wake));
	usb_host_model i_host (.i_clock(clk), .i_tx(tx), .o_link(link), .o_bus_active(act),
		.o_host_resume(res));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic print_verdict();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// held until waitrequest is seen low, then released
	task automatic access(input logic [6:0] idx, input logic w, input logic [7:0] v);
		int n;
		@(posedge clk);
		addr <= {idx, 2'b00};
		rd <= !w;
		wr_en <= w;
		wdata <= {24'h000000, v};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		d = rdata[7:0];
		rd <= 1'b0;
		wr_en <= 1'b0;
		if (waitreq !== 1'b0) begin
			check("waitrequest", 8'h00, {7'h00, waitreq});
			print_verdict();
		end
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] v);
		access(idx, 1'b1, v);
	endtask
	task automatic rc(input logic [6:0] idx, input logic [7:0] exp, input string what);
		access(idx, 1'b0, 8'h00);
		check(what, exp, d);
	endtask
	// 2 us at 40 MHz, the firmware settling gap
	task automatic gap();
		repeat (80) @(posedge clk);
	endtask
	task automatic wait_int();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		check("usb_int", 8'h01, {7'h00, irq});
		if (irq !== 1'b1)
			print_verdict();
	endtask

	task automatic t_reset();
		rc(7'h46, 8'h00, "command_status");
		rc(7'h1A, 8'h00, "status_control");
		wr(7'h10, 8'hFF);
		rc(7'h10, 8'h00, "unmapped");
	endtask
	task automatic t_read();
		i_host.send(2'd0, 3, 8'hA0, 1'b0, 1'b0);
		wr(7'h46, 8'h00);
		wr(7'h46, 8'h01);
		gap();
		rc(7'h46, 8'h41, "ready ep0");
		for (int k = 0; k < 3; k++) begin
			rc(7'h48, 8'hA0 + 8'(k), "ep0 byte");
			gap();
			rc(7'h46, (k < 2) ? 8'h41 : 8'h01, "ready after byte");
		end
		wr(7'h46, 8'h03);
		wr(7'h46, 8'h02);
		gap();
		rc(7'h46, 8'h02, "released ep0");
	endtask
	task automatic t_setup();
		i_host.send(2'd0, 8, 8'h10, 1'b1, 1'b0);
		rc(7'h46, 8'h22, "setup flag");
		wr(7'h46, 8'h00);
		rc(7'h46, 8'h00, "setup cleared");
		wr(7'h46, 8'h04);
		wr(7'h46, 8'h01);
		gap();
		rc(7'h46, 8'h01, "flushed ep0");
		wr(7'h46, 8'h00);
	endtask
	task automatic t_zero();
		i_host.send(2'd1, 0, 8'h00, 1'b0, 1'b1);
		wr(7'h46, 8'h08);
		rc(7'h46, 8'h88, "zero flag ep1");
		wr(7'h46, 8'h09);
		gap();
		rc(7'h46, 8'h89, "zero packet");
		access(7'h49, 1'b0, 8'h00);
		rc(7'h46, 8'h09, "zero cleared");
		wr(7'h46, 8'h0B);
		wr(7'h46, 8'h0A);
	endtask
	task automatic t_write();
		wr(7'h46, 8'h0B);
		gap();
		for (int k = 0; k < 8; k++) begin
			rc(7'h46, 8'h4B, "ready write ep1");
			wr(7'h49, 8'h50 + 8'(k));
			gap();
		end
		rc(7'h46, 8'h0B, "ep1 full");
		wr(7'h46, 8'h09);
		wr(7'h46, 8'h08);
		i_host.fetch(2'd1, pend, cnt, bytes);
		check("tx pending", 8'h01, {7'h00, pend});
		check("tx count", 8'h08, {4'h0, cnt});
		for (int k = 0; k < 8; k++)
			check("tx byte", 8'h50 + 8'(k), bytes[8*k +: 8]);
		repeat (2) @(posedge clk);
		check("active pipe", 8'h01, {6'h00, pipe});
	endtask
	task automatic t_empty();
		wr(7'h46, 8'h02);
		wr(7'h46, 8'h03);
		gap();
		rc(7'h46, 8'h43, "ready empty ep0");
		wr(7'h46, 8'h01);
		wr(7'h46, 8'h00);
		i_host.fetch(2'd0, pend, cnt, bytes);
		check("empty pending", 8'h01, {7'h00, pend});
		check("empty count", 8'h00, {4'h0, cnt});
	endtask
	task automatic t_busy();
		i_host.hold(2'd2, 1'b1);
		wr(7'h46, 8'h12);
		wr(7'h46, 8'h13);
		gap();
		rc(7'h46, 8'h13, "host owns ep2");
		i_host.hold(2'd2, 1'b0);
		gap();
		rc(7'h46, 8'h53, "ep2 ready");
		wr(7'h46, 8'h12);
	endtask
	task automatic t_suspend();
		i_host.lines(1'b0, 1'b0);
		wait_int();
		rc(7'h1A, 8'h01, "suspended");
		wr(7'h1A, 8'h02);
		repeat (3) @(posedge clk);
		check("remote wake", 8'h01, {7'h00, wake});
		i_host.lines(1'b0, 1'b1);
		wait_int();
		rc(7'h1A, 8'h09, "resumed");
		check("wake dropped", 8'h00, {7'h00, wake});
		i_host.lines(1'b1, 1'b0);
		wait_int();
		rc(7'h1A, 8'h00, "awake");
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		addr = '0;
		rd = 1'b0;
		wr_en = 1'b0;
		wdata = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_read();
		t_setup();
		t_zero();
		t_write();
		t_empty();
		t_busy();
		t_suspend();
		print_verdict();
	end
endmodule
